// File: include/dspwm_defines.vh
// Constants for the dual-slope PWM timer: offsets, fields, resets, counts
`ifndef DSPWM_DEFINES_VH
`define DSPWM_DEFINES_VH

// Register offsets (byte addresses)
`define DSPWM_OFS_CTRL 8'h00
`define DSPWM_OFS_COUNT 8'h04
`define DSPWM_OFS_CMPA 8'h08
`define DSPWM_OFS_CMPB 8'h0C
`define DSPWM_OFS_CAPT 8'h10
`define DSPWM_OFS_FLAGS 8'h14
`define DSPWM_OFS_PINDIR 8'h18
`define DSPWM_OFS_STATUS 8'h1C

// Control register field positions
`define DSPWM_CTRL_MODE_LSB 0
`define DSPWM_CTRL_ACT_LSB 4
`define DSPWM_CTRL_CLK_LSB 8

// Flag register bit positions
`define DSPWM_FLAG_OVF 0
`define DSPWM_FLAG_CMP_LSB 1

// Reset values
`define DSPWM_RST_CTRL 16'h0000
`define DSPWM_RST_WORD 16'h0000

// Waveform mode selector codes
`define DSPWM_MODE_PC8 4'h1
`define DSPWM_MODE_PC9 4'h2
`define DSPWM_MODE_PC10 4'h3
`define DSPWM_MODE_PFC_CAPT 4'h8
`define DSPWM_MODE_PFC_CMPA 4'h9
`define DSPWM_MODE_PC_CAPT 4'hA
`define DSPWM_MODE_PC_CMPA 4'hB

// Fixed TOP values
`define DSPWM_TOP_8 16'h00FF
`define DSPWM_TOP_9 16'h01FF
`define DSPWM_TOP_10 16'h03FF
`define DSPWM_TOP_MAX 16'hFFFF

// Output action codes
`define DSPWM_ACT_TOGGLE 2'h1
`define DSPWM_ACT_NONINV 2'h2
`define DSPWM_ACT_INV 2'h3

// Prescaler selector codes and divide counts
`define DSPWM_CLK_STOP 3'h0
`define DSPWM_CLK_DIV1 3'h1
`define DSPWM_CLK_DIV8 3'h2
`define DSPWM_CLK_DIV64 3'h3
`define DSPWM_CLK_DIV256 3'h4
`define DSPWM_CLK_DIV1024 3'h5
`define DSPWM_DIV8 10'h007
`define DSPWM_DIV64 10'h03F
`define DSPWM_DIV256 10'h0FF
`define DSPWM_DIV1024 10'h3FF

`endif

// File: verilog/dspwm_prescaler.v
// Prescaler producing the one-cycle timer clock enable
`timescale 1ns/100ps
`default_nettype none
`include "dspwm_defines.vh"

module dspwm_prescaler (
  input wire core_clk,
  input wire srst,
  input wire [2:0] clk_sel,
  output wire tick
);

  reg [9:0] div_q;
  reg [9:0] last;

  // Terminal count for the selected divider
  always @* begin
    case (clk_sel)
      `DSPWM_CLK_DIV8: last = `DSPWM_DIV8;
      `DSPWM_CLK_DIV64: last = `DSPWM_DIV64;
      `DSPWM_CLK_DIV256: last = `DSPWM_DIV256;
      `DSPWM_CLK_DIV1024: last = `DSPWM_DIV1024;
      default: last = 10'h000;
    endcase
  end

  // Free-running divide counter, cleared while stopped
  always @(posedge core_clk) begin
    if (srst || clk_sel == `DSPWM_CLK_STOP) begin
      div_q <= 10'h000;
    end else if (div_q >= last) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end

  assign tick = (clk_sel != `DSPWM_CLK_STOP) && (clk_sel <= `DSPWM_CLK_DIV1024)
    && (div_q >= last);

endmodule // dspwm_prescaler

`default_nettype wire

// File: verilog/dspwm_compare.v
// One compare channel: buffered compare value and output level
`timescale 1ns/100ps
`default_nettype none
`include "dspwm_defines.vh"

module dspwm_compare #(
  parameter WIDTH = 16
) (
  input wire core_clk,
  input wire srst,
  input wire buf_wr,
  input wire [WIDTH-1:0] buf_wdata,
  input wire load,
  input wire tick,
  input wire [WIDTH-1:0] count,
  input wire [WIDTH-1:0] top,
  input wire slope_up,
  input wire [1:0] action,
  input wire toggle_ok,
  output reg [WIDTH-1:0] buf_q,
  output reg [WIDTH-1:0] act_q,
  output wire match,
  output reg level_q
);

  // Match only on timer ticks against the active value
  assign match = tick && (count == act_q);

  // Buffered write, active copy taken at the update point
  always @(posedge core_clk) begin
    if (srst) begin
      buf_q <= {WIDTH{1'b0}};
      act_q <= {WIDTH{1'b0}};
    end else begin
      if (buf_wr) begin
        buf_q <= buf_wdata;
      end
      if (load) begin
        act_q <= buf_wr ? buf_wdata : buf_q;
      end
    end
  end

  // Output level: clear going up, set going down, inverted if asked
  always @(posedge core_clk) begin
    if (srst) begin
      level_q <= 1'b0;
    end else if (match) begin
      case (action)
        `DSPWM_ACT_TOGGLE: begin
          if (toggle_ok) begin
            level_q <= ~level_q;
          end
        end
        `DSPWM_ACT_NONINV: level_q <= ~slope_up;
        `DSPWM_ACT_INV: level_q <= slope_up;
        default: level_q <= level_q;
      endcase
    end
  end

endmodule // dspwm_compare

`default_nettype wire

// File: verilog/dspwm_timer.v
// Dual-slope PWM timer: counter, TOP select, flags, registers, pins
// Functional notes
// - Modes 1,2,3,10,11 run phase correct PWM
// - Non-inverting: clear on up match, set down
// - TOP fixed, capture or compare A by mode
// - Hold TOP one tick then count down
// - Overflow flag set at BOTTOM
// - Compare A/capture flag set at TOP update
// - Compare flag set on every match
// - Fixed TOP masks written compare bits
// - Action two non-inverted, three inverted PWM
// - Pin driven only when direction is output
// - Compare zero low, compare TOP high
// - Mode 11 action 1 toggles output A
// - Period is two times divider times TOP
// - Register TOP from 0x0003 to full range
// - Phase correct updates at TOP
// - Modes 8,9 run frequency correct PWM
// - Frequency correct updates and overflows at BOTTOM
// - Compare writes go to buffer first
// - Nonzero action overrides normal port function
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dspwm_defines.vh"

module dspwm_timer #(
  parameter NCH = 2,
  parameter WIDTH = 16
) (
  input wire core_clk,
  input wire srst,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [15:0] rd_data,
  input wire [NCH-1:0] port_data,
  output reg [NCH-1:0] pin_out,
  output reg [NCH-1:0] pin_oe_n
);

  reg [15:0] ctrl_q;
  reg [WIDTH-1:0] count_value;
  reg slope_up_q;
  reg [WIDTH-1:0] capture_value;
  reg overflow_flag;
  reg capture_flag;
  reg [NCH-1:0] cmp_flag_q;
  reg [NCH-1:0] pin_direction_bit;
  reg [WIDTH-1:0] top;
  reg [WIDTH-1:0] wmask;
  reg [15:0] rd_mux;

  wire [3:0] waveform_mode_sel;
  wire [2:0] clk_sel;
  wire tick;
  wire mode_pc;
  wire mode_pfc;
  wire dual;
  wire run;
  wire at_top;
  wire at_bottom;
  wire top_reg;
  wire slope_up;
  wire upd;
  wire wr_ctrl;
  wire wr_count;
  wire wr_capt;
  wire wr_flags;
  wire wr_pindir;
  wire [NCH*WIDTH-1:0] buf_all;
  wire [NCH*WIDTH-1:0] act_all;
  wire [NCH-1:0] match;
  wire [NCH-1:0] level;
  wire [NCH-1:0] cmp_wr;
  wire [WIDTH-1:0] compare_a_value;
  wire [WIDTH-1:0] masked_wdata;

  // Control fields
  assign waveform_mode_sel = ctrl_q[`DSPWM_CTRL_MODE_LSB +: 4];
  assign clk_sel = ctrl_q[`DSPWM_CTRL_CLK_LSB +: 3];

  // Write decode
  assign wr_ctrl = wr_en && (addr == `DSPWM_OFS_CTRL);
  assign wr_count = wr_en && (addr == `DSPWM_OFS_COUNT);
  assign wr_capt = wr_en && (addr == `DSPWM_OFS_CAPT);
  assign wr_flags = wr_en && (addr == `DSPWM_OFS_FLAGS);
  assign wr_pindir = wr_en && (addr == `DSPWM_OFS_PINDIR);
  assign cmp_wr[0] = wr_en && (addr == `DSPWM_OFS_CMPA);
  assign cmp_wr[1] = wr_en && (addr == `DSPWM_OFS_CMPB);

  // Mode decode
  assign mode_pc = (waveform_mode_sel == `DSPWM_MODE_PC8)
    || (waveform_mode_sel == `DSPWM_MODE_PC9)
    || (waveform_mode_sel == `DSPWM_MODE_PC10)
    || (waveform_mode_sel == `DSPWM_MODE_PC_CAPT)
    || (waveform_mode_sel == `DSPWM_MODE_PC_CMPA);
  assign mode_pfc = (waveform_mode_sel == `DSPWM_MODE_PFC_CAPT)
    || (waveform_mode_sel == `DSPWM_MODE_PFC_CMPA);
  assign dual = mode_pc || mode_pfc;
  assign top_reg = (waveform_mode_sel == `DSPWM_MODE_PC_CAPT)
    || (waveform_mode_sel == `DSPWM_MODE_PC_CMPA) || mode_pfc;

  assign compare_a_value = act_all[0 +: WIDTH];

  // TOP selection per mode
  always @* begin
    case (waveform_mode_sel)
      `DSPWM_MODE_PC8: top = `DSPWM_TOP_8;
      `DSPWM_MODE_PC9: top = `DSPWM_TOP_9;
      `DSPWM_MODE_PC10: top = `DSPWM_TOP_10;
      `DSPWM_MODE_PC_CAPT: top = capture_value;
      `DSPWM_MODE_PFC_CAPT: top = capture_value;
      `DSPWM_MODE_PC_CMPA: top = compare_a_value;
      `DSPWM_MODE_PFC_CMPA: top = compare_a_value;
      default: top = `DSPWM_TOP_MAX;
    endcase
  end

  // Resolution mask for compare writes under fixed TOP
  always @* begin
    case (waveform_mode_sel)
      `DSPWM_MODE_PC8: wmask = `DSPWM_TOP_8;
      `DSPWM_MODE_PC9: wmask = `DSPWM_TOP_9;
      `DSPWM_MODE_PC10: wmask = `DSPWM_TOP_10;
      default: wmask = `DSPWM_TOP_MAX;
    endcase
  end
  assign masked_wdata = wdata & wmask;

  // Timer clock enable
  dspwm_prescaler u_presc (
    .core_clk(core_clk),
    .srst(srst),
    .clk_sel(clk_sel),
    .tick(tick)
  );

  // Counter events only on enabled ticks in a dual-slope mode
  assign run = tick && dual;
  assign at_top = run && slope_up_q && (count_value >= top);
  assign at_bottom = run && (count_value == {WIDTH{1'b0}});

  // Effective slope: a match at TOP counts as falling, at zero as rising
  assign slope_up = (count_value == {WIDTH{1'b0}})
    || (slope_up_q && (count_value != top));

  // Double-buffer update point: TOP for phase correct, BOTTOM for frequency correct, every cycle otherwise
  assign upd = ~dual
    || (mode_pc && at_top)
    || (mode_pfc && at_bottom);

  // Up/down counter with one-tick hold at TOP
  always @(posedge core_clk) begin
    if (srst) begin
      count_value <= {WIDTH{1'b0}};
      slope_up_q <= 1'b1;
    end else if (wr_count) begin
      count_value <= wdata[WIDTH-1:0];
    end else if (run) begin
      if (slope_up_q) begin
        if (count_value >= top) begin
          slope_up_q <= 1'b0;
          count_value <= count_value - {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
          count_value <= count_value + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end else if (count_value == {WIDTH{1'b0}}) begin
        slope_up_q <= 1'b1;
        count_value <= {{(WIDTH-1){1'b0}}, 1'b1};
      end else begin
        count_value <= count_value - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // Compare channels and their pins
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      wire [1:0] act;
      assign act = ctrl_q[`DSPWM_CTRL_ACT_LSB + 2*i +: 2];

      dspwm_compare #(
        .WIDTH(WIDTH)
      ) u_cmp (
        .core_clk(core_clk),
        .srst(srst),
        .buf_wr(cmp_wr[i]),
        .buf_wdata(masked_wdata),
        .load(upd),
        .tick(run),
        .count(count_value),
        .top(top),
        .slope_up(slope_up),
        .action(act),
        .toggle_ok((i == 0) && (waveform_mode_sel == `DSPWM_MODE_PC_CMPA
          || waveform_mode_sel == `DSPWM_MODE_PFC_CMPA)),
        .buf_q(buf_all[i*WIDTH +: WIDTH]),
        .act_q(act_all[i*WIDTH +: WIDTH]),
        .match(match[i]),
        .level_q(level[i])
      );

      // Pin: compare level overrides port data when action is nonzero, driven if output
      always @(posedge core_clk) begin
        if (srst) begin
          pin_out[i] <= 1'b0;
          pin_oe_n[i] <= 1'b1;
        end else begin
          pin_out[i] <= (act != 2'h0) ? level[i] : port_data[i];
          pin_oe_n[i] <= ~pin_direction_bit[i];
        end
      end
    end
  endgenerate

  // Sticky flags: hardware set wins over write-one clear
  always @(posedge core_clk) begin
    if (srst) begin
      overflow_flag <= 1'b0;
      capture_flag <= 1'b0;
      cmp_flag_q <= {NCH{1'b0}};
    end else begin
      overflow_flag <= (overflow_flag
        & ~(wr_flags & wdata[`DSPWM_FLAG_OVF]))
        | at_bottom;
      capture_flag <= (capture_flag
        & ~(wr_flags & wdata[`DSPWM_FLAG_CMP_LSB + NCH]))
        | (at_top && (waveform_mode_sel == `DSPWM_MODE_PC_CAPT
        || waveform_mode_sel == `DSPWM_MODE_PFC_CAPT));
      cmp_flag_q <= (cmp_flag_q
        & ~({NCH{wr_flags}} & wdata[`DSPWM_FLAG_CMP_LSB +: NCH]))
        | match
        | {{(NCH-1){1'b0}}, at_top
        && (waveform_mode_sel == `DSPWM_MODE_PC_CMPA
        || waveform_mode_sel == `DSPWM_MODE_PFC_CMPA)};
    end
  end

  // Software-written configuration
  always @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= `DSPWM_RST_CTRL;
      capture_value <= `DSPWM_RST_WORD;
      pin_direction_bit <= {NCH{1'b0}};
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata;
      end
      if (wr_capt) begin
        capture_value <= wdata[WIDTH-1:0];
      end
      if (wr_pindir) begin
        pin_direction_bit <= wdata[NCH-1:0];
      end
    end
  end

  // Read decode
  always @* begin
    if (addr == `DSPWM_OFS_CTRL) begin
      rd_mux = ctrl_q;
    end else if (addr == `DSPWM_OFS_COUNT) begin
      rd_mux = count_value;
    end else if (addr == `DSPWM_OFS_CMPA) begin
      rd_mux = buf_all[0 +: WIDTH];
    end else if (addr == `DSPWM_OFS_CMPB) begin
      rd_mux = buf_all[WIDTH +: WIDTH];
    end else if (addr == `DSPWM_OFS_CAPT) begin
      rd_mux = capture_value;
    end else if (addr == `DSPWM_OFS_FLAGS) begin
      rd_mux = {{(14-NCH){1'b0}}, capture_flag, cmp_flag_q, overflow_flag};
    end else if (addr == `DSPWM_OFS_PINDIR) begin
      rd_mux = {{(16-NCH){1'b0}}, pin_direction_bit};
    end else if (addr == `DSPWM_OFS_STATUS) begin
      rd_mux = {15'h0000, ~slope_up_q};
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (srst) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= rd_en ? rd_mux : 16'h0000;
    end
  end

endmodule // dspwm_timer

`default_nettype wire

// File: verification/dspwm_chk.sv
// Port checker for the dual-slope PWM timer
`timescale 1ns/100ps
`default_nettype none
module dspwm_chk #(
  parameter NCH = 2
) (
  input wire core_clk,
  input wire srst,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [15:0] rd_data,
  input wire [NCH-1:0] port_data,
  input wire [NCH-1:0] pin_out,
  input wire [NCH-1:0] pin_oe_n
);
  logic [15:0] ctrl_q;
  logic [15:0] cmpa_q;
  logic [11:0] quiet_q;
  logic dir_wr;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  assign dir_wr = wr_en && addr == 8'h18;
  // Shadows of written control and compare A buffer, quiet time
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= 16'h0000;
      cmpa_q <= 16'h0000;
      quiet_q <= 12'h000;
    end else begin
      if (wr_en && addr == 8'h00)
        ctrl_q <= wdata;
      if (wr_en && addr == 8'h08)
        case (ctrl_q[3:0])
          4'h1: cmpa_q <= wdata & 16'h00FF;
          4'h2: cmpa_q <= wdata & 16'h01FF;
          4'h3: cmpa_q <= wdata & 16'h03FF;
          default: cmpa_q <= wdata;
        endcase
      if (wr_en)
        quiet_q <= 12'h000;
      else if (quiet_q != 12'hFFF)
        quiet_q <= quiet_q + 12'h001;
    end
  end
  sequence s_dir_wr;
    dir_wr;
  endsequence
  sequence s_settled;
    quiet_q == 12'hFFF && ctrl_q[10:0] ==? 11'b001_1?1?_0001;
  endsequence
  property p_rd_idle;
    !$past(rd_en) |-> rd_data == 16'h0000;
  endproperty
  property p_rd_unmap;
    rd_en && (addr[1:0] != 2'h0 || addr > 8'h1C) |=> rd_data == 16'h0000;
  endproperty
  property p_rd_ctrl;
    rd_en && addr == 8'h00 |=> rd_data[10:0] == $past(ctrl_q[10:0]);
  endproperty
  property p_cmpa_buf;
    rd_en && addr == 8'h08 |=> rd_data == $past(cmpa_q);
  endproperty
  property p_oe_val;
    s_dir_wr |-> ##2 pin_oe_n == ~$past(wdata[1:0], 2);
  endproperty
  property p_oe_cause;
    $changed(pin_oe_n) |-> $past(dir_wr) || $past(dir_wr, 2);
  endproperty
  property p_port;
    !$past(srst) |->
      ($past(ctrl_q[5:4]) != 2'h0 || pin_out[0] == $past(port_data[0])) &&
      ($past(ctrl_q[7:6]) != 2'h0 || pin_out[1] == $past(port_data[1]));
  endproperty
  property p_const;
    s_settled ##0 (cmpa_q == 16'h0000 || cmpa_q == 16'h00FF) |->
      pin_out[0] == (ctrl_q[4] ^ (cmpa_q != 16'h0000));
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read");
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback");
  a_cmpa_buf: assert property (p_cmpa_buf) else $error("buffer read");
  a_oe_val: assert property (p_oe_val) else $error("drive enable");
  a_oe_cause: assert property (p_oe_cause) else $error("enable moved");
  a_port: assert property (p_port) else $error("port pass");
  a_const: assert property (p_const) else $error("fixed level");
endmodule // dspwm_chk
bind dspwm_timer dspwm_chk #(.NCH(NCH)) u_chk (
  .core_clk(core_clk),
  .srst(srst),
  .addr(addr),
  .wdata(wdata),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .rd_data(rd_data),
  .port_data(port_data),
  .pin_out(pin_out),
  .pin_oe_n(pin_oe_n)
);
`default_nettype wire

// File: verification/dspwm_load.sv
// Load on the PWM pins: pull-downs and high-time counters
`timescale 1ns/100ps
`default_nettype none
module dspwm_load (
  input wire logic core_clk,
  input wire logic clr,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe_n,
  output wire logic [1:0] pin_lvl,
  output logic [7:0] hi0,
  output logic [7:0] hi1
);
  // Undriven pin falls to its pull-down
  assign pin_lvl = pin_out & ~pin_oe_n;
  // Count cycles each pin sits high
  always @(posedge core_clk) begin
    if (clr) begin
      hi0 <= 8'h00;
      hi1 <= 8'h00;
    end else begin
      hi0 <= hi0 + {7'h00, pin_lvl[0]};
      hi1 <= hi1 + {7'h00, pin_lvl[1]};
    end
  end
endmodule // dspwm_load
`default_nettype wire

// File: verification/dspwm_timer_tb_top.sv
// Testbench for the dual-slope PWM timer
`timescale 1ns/100ps
`default_nettype none
module dspwm_timer_tb_top;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [1:0] port_data = 2'h0;
  logic clr = 1'b1;
  wire [15:0] rd_data;
  wire [1:0] pin_out, pin_oe_n, pin_lvl;
  wire [7:0] hi0, hi1;
  int err_total = 0;
  int checks = 0;
  int i, j, k, d;
  logic [15:0] v, c;
  logic [15:0] cq [0:23];
  logic up;
  logic [3:0] md [0:3] = '{4'hB, 4'h9, 4'hA, 4'h8};
  // 10 MHz clock
  always #50 core_clk = ~core_clk;
  dspwm_timer #(.NCH(2), .WIDTH(16)) dut (
    .core_clk(core_clk),
    .srst(srst),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .port_data(port_data),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n)
  );
  dspwm_load u_load (
    .core_clk(core_clk),
    .clr(clr),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .pin_lvl(pin_lvl),
    .hi0(hi0),
    .hi1(hi1)
  );
  // Compare and count
  task automatic cmp(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [15:0] dt);
    @(posedge core_clk);
    addr <= a;
    wdata <= dt;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  // Read, data taken in the answer cycle
  task automatic chk_rd(input string n, input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    cmp(n, rd_data, e);
  endtask
  // Back-to-back reads of the counter
  task automatic burst;
    @(posedge core_clk);
    addr <= 8'h04;
    rd_en <= 1'b1;
    for (int n = 0; n < 24; n++) begin
      @(posedge core_clk);
      if (n == 23)
        rd_en <= 1'b0;
      @(negedge core_clk);
      cq[n] = rd_data;
    end
  endtask
  // High-time window on the load
  task automatic win(input int n);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task report_and_stop;
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Guard against a hung run
  initial begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    chk_rd("ctrl", 8'h00, 16'h0000);
    chk_rd("gap", 8'h02, 16'h0000);
    chk_rd("spare", 8'h20, 16'h0000);
    cmp("oe", {14'h0, pin_oe_n}, 16'h0003);
    for (i = 1; i < 4; i++) begin
      wr(8'h00, 16'(i));
      wr(8'h08, 16'hFFFF);
      wr(8'h0C, 16'hFFFF);
      chk_rd("cmpa", 8'h08, 16'hFFFF >> (9 - i));
      chk_rd("cmpb", 8'h0C, 16'hFFFF >> (9 - i));
    end
    wr(8'h00, 16'h0000);
    wr(8'h08, 16'hFFFF);
    chk_rd("cmpa", 8'h08, 16'hFFFF);
    wr(8'h08, 16'h0003);
    wr(8'h0C, 16'h0001);
    wr(8'h10, 16'h0003);
    wr(8'h04, 16'h0002);
    wr(8'h00, 16'h000B);
    repeat (10) @(posedge core_clk);
    chk_rd("hold", 8'h04, 16'h0002);
    wr(8'h00, 16'h010B);
    repeat (20) @(posedge core_clk);
    burst;
    v = cq[1];
    up = cq[1] > cq[0];
    for (i = 2; i < 24; i++) begin
      if (up && v == 16'h0003)
        up = 1'b0;
      else if (!up && v == 16'h0000)
        up = 1'b1;
      v = up ? v + 16'h0001 : v - 16'h0001;
      cmp("count", cq[i], v);
    end
    wr(8'h00, 16'h000B);
    chk_rd("flags", 8'h14, 16'h0007);
    wr(8'h14, 16'h000F);
    chk_rd("flags", 8'h14, 16'h0000);
    port_data <= 2'h2;
    wr(8'h18, 16'h0003);
    repeat (3) @(posedge core_clk);
    cmp("port", {14'h0, pin_lvl}, 16'h0002);
    wr(8'h18, 16'h0000);
    repeat (3) @(posedge core_clk);
    cmp("float", {14'h0, pin_lvl}, 16'h0000);
    wr(8'h18, 16'h0003);
    wr(8'h00, 16'h011B);
    repeat (20) @(posedge core_clk);
    win(24);
    cmp("toggle", {8'h0, hi0}, 16'h000C);
    // Output B duty in modes 8 to 11 at divide by 1 and 8
    for (i = 0; i < 4; i++)
      for (j = 1; j < 3; j++)
        for (k = 2; k < 4; k++) begin
          d = (j == 1) ? 1 : 8;
          wr(8'h00, 16'(j << 8 | k << 6) | {12'h0, md[i]});
          repeat (24 * d + 10) @(posedge core_clk);
          win(12 * d);
          cmp("duty", {8'h0, hi1}, 16'((k == 2 ? 4 : 8) * d));
        end
    for (i = 0; i < 4; i++) begin
      c = i[0] ? 16'h00FF : 16'h0000;
      wr(8'h00, 16'h0001);
      wr(8'h08, c);
      wr(8'h0C, c ^ 16'h00FF);
      wr(8'h00, 16'(i[1] ? 16'h01F1 : 16'h01A1));
      repeat (4200) @(posedge core_clk);
      v = {14'h0, ~(i[1] ^ i[0]), i[1] ^ i[0]};
      cmp("level", {14'h0, pin_out}, v);
    end
    report_and_stop;
  end
endmodule // dspwm_timer_tb_top
`default_nettype wire
